// *** rtl/psumon_pkg.sv ***
/*
  Constants shared by the supply monitor parameter block: clock rate, refresh periods,
  process-data layout, parameter indices, reset values and event bit positions.
  Assumes a single 10 MHz clock; everything else derives from these values.
*/
package psumon_pkg;

  // timing
  localparam int unsigned CLOCK_HZ         = 10_000_000;
  localparam int unsigned PD_PERIOD_MS     = 2;
  localparam int unsigned SNAP_PERIOD_MS   = 50;
  localparam int unsigned PD_CYCLES_DEF    = PD_PERIOD_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SNAP_CYCLES_DEF  = SNAP_PERIOD_MS * (CLOCK_HZ / 1000);
  // overpower window and rest, counted in refresh ticks
  localparam int unsigned BOOST_MAX_TICKS  = 100;
  localparam int unsigned BOOST_REST_TICKS = 200;

  // process-data image layout
  localparam int unsigned CHANNELS         = 4;
  localparam int unsigned PD_WIDTH         = 120;
  localparam int unsigned PD_TOTAL_POS     = 104;
  localparam int unsigned PD_VOLT_POS      = 88;
  localparam int unsigned PD_CH_FIRST_POS  = 72;
  localparam int unsigned PD_CH_STEP       = 16;
  localparam int unsigned PD_STATE_POS     = 16;
  localparam int unsigned PD_OVERLOAD_POS  = 8;
  localparam int unsigned PD_SHORT_POS     = 0;

  // parameter indices
  localparam logic [7:0] IDX_NV_STATUS      = 8'h40;
  localparam logic [7:0] IDX_EVENTS         = 8'h41;
  localparam logic [7:0] IDX_STANDBY        = 8'h65;
  localparam logic [7:0] IDX_CONFIG         = 8'h67;
  localparam logic [7:0] IDX_TOTAL_PREALARM = 8'h68;
  localparam logic [7:0] IDX_SETPOINT       = 8'h69;
  localparam logic [7:0] IDX_CH_ENABLE      = 8'h6a;
  localparam logic [7:0] IDX_TRIP           = 8'h6c;
  localparam logic [7:0] IDX_CH_PREALARM    = 8'h6d;
  localparam logic [7:0] SUB_WHOLE          = 8'h00;
  localparam logic [7:0] SUB_CH_LIMIT       = 8'h04;

  // reset values; analog quantities in 10 mV, 10 mA and 0.01 % steps
  localparam logic        RST_STANDBY        = 1'b0;
  localparam logic [7:0]  RST_CONFIG         = 8'h02;
  localparam logic [15:0] CONFIG_MAX         = 16'h0003;
  localparam logic [15:0] RST_SETPOINT       = 16'h0992;
  localparam logic [15:0] RST_TOTAL_PREALARM = 16'h07d0;
  localparam logic [3:0]  RST_CH_ENABLE      = 4'hf;
  localparam logic [15:0] RST_TRIP           = 16'hffff;
  localparam logic [15:0] RST_CH_PREALARM    = 16'h1f62;

  // event word bit positions
  localparam int unsigned EV_OUTPUT_GOOD        = 0;
  localparam int unsigned EV_OUTPUT_LOW_WARNING = 1;
  localparam int unsigned EV_OVERPOWER          = 2;
  localparam int unsigned EV_CAPACITOR_OVERTEMP = 3;
  localparam int unsigned EV_UNIT_OVERTEMP      = 4;
  localparam int unsigned EV_OVERLOAD           = 5;

  typedef enum logic [1:0] {
    BOOST_IDLE = 2'b00,
    BOOST_ON   = 2'b01,
    BOOST_REST = 2'b10
  } psumon_boost_t;

endpackage

// *** rtl/psumon_tick.sv ***
/*
  Free-running divider giving a one-cycle enable pulse every PERIOD clocks.
  Assumes PERIOD between 1 and 2**20.
*/
`timescale 1ns/1ps
module psumon_tick import psumon_pkg::*; #(
  parameter int unsigned PERIOD = 2
) (
  input  wire logic clock,
  input  wire logic srst,
  output logic      tick
);

  logic [19:0] count;
  logic [19:0] next_count;
  logic        next_tick;

  always_comb begin
    next_tick  = 1'b0;
    next_count = count + 20'h0_0001;
    if (count == 20'(PERIOD - 1)) begin
      next_count = '0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

// *** rtl/psumon_boost_limit.sv ***
/*
  Short-term overpower manager: grants overpower while demanded, for at most
  BOOST_MAX_TICKS refresh ticks, then forces a rest of BOOST_REST_TICKS before the next grant.
  Assumes step is a one-cycle pulse from the refresh divider.
*/
`timescale 1ns/1ps
module psumon_boost_limit import psumon_pkg::*; (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic step,
  input  wire logic demand,
  output logic      active
);

  psumon_boost_t state;
  psumon_boost_t next_state;
  logic [7:0]    ticks;
  logic [7:0]    next_ticks;
  logic          next_active;

  always_comb begin
    next_state = state;
    next_ticks = ticks;
    case (state)
      BOOST_IDLE: begin
        if (demand) begin
          next_state = BOOST_ON;
          next_ticks = '0;
        end
      end
      BOOST_ON: begin
        // dropping demand early still costs a full rest: keeps average power bounded
        if (!demand) begin
          next_state = BOOST_REST;
          next_ticks = '0;
        end else if (step) begin
          if (ticks == 8'(BOOST_MAX_TICKS - 1)) begin
            next_state = BOOST_REST;
            next_ticks = '0;
          end else begin
            next_ticks = ticks + 8'h01;
          end
        end
      end
      BOOST_REST: begin
        if (step) begin
          if (ticks == 8'(BOOST_REST_TICKS - 1)) begin
            next_state = BOOST_IDLE;
            next_ticks = '0;
          end else begin
            next_ticks = ticks + 8'h01;
          end
        end
      end
      default: begin
        next_state = BOOST_IDLE;
        next_ticks = '0;
      end
    endcase
    next_active = (next_state == BOOST_ON);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state  <= BOOST_IDLE;
      ticks  <= '0;
      active <= 1'b0;
    end else begin
      state  <= next_state;
      ticks  <= next_ticks;
      active <= next_active;
    end
  end

  // helper: refresh ticks seen during one grant
  logic [7:0] on_ticks;
  always_ff @(posedge clock) begin
    if (srst || !active) begin
      on_ticks <= '0;
    end else if (step) begin
      on_ticks <= on_ticks + 8'h01;
    end
  end

  boost_cap_a: assert property (@(posedge clock) disable iff (srst)
    on_ticks <= 8'(BOOST_MAX_TICKS)) else $error("overpower grant exceeded its window");

endmodule

// *** rtl/psumon_param_map.sv ***
/*
  Monitoring and configuration data block of a multi-output supply: builds the cyclic
  process-data image, snapshots status into link-visible storage and serves acyclic
  parameter reads and writes by index and subindex.
  Assumes the link stack presents one request per cycle and that sensor inputs are synchronous.
*/
`timescale 1ns/1ps
module psumon_param_map import psumon_pkg::*; #(
  parameter int unsigned PD_CYCLES   = PD_CYCLES_DEF,
  parameter int unsigned SNAP_CYCLES = SNAP_CYCLES_DEF
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  param_req_valid,
  input  wire logic                  param_req_write,
  input  wire logic [7:0]            param_index,
  input  wire logic [7:0]            param_subindex,
  input  wire logic [15:0]           param_wdata,
  output logic                       param_rsp_valid,
  output logic                       param_rsp_error,
  output logic [15:0]                param_rdata,
  output logic                       pd_valid,
  output logic [PD_WIDTH-1:0]        pd_data,
  input  wire logic [15:0]           meas_total_current,
  input  wire logic [15:0]           meas_output_voltage,
  input  wire logic [3:0][15:0]      meas_channel_current,
  input  wire logic [3:0]            breaker_on_state,
  input  wire logic [3:0]            breaker_overload_trip,
  input  wire logic [3:0]            breaker_short_trip,
  input  wire logic [7:0]            nv_health,
  input  wire logic                  output_good,
  input  wire logic                  output_low_warning,
  input  wire logic                  capacitor_overtemp,
  input  wire logic                  unit_overtemp,
  input  wire logic                  overload,
  input  wire logic                  overpower_demand,
  output logic                       overpower_active,
  output logic [15:0]                output_voltage_setpoint,
  output logic                       standby_request,
  output logic [7:0]                 config_source_select,
  output logic [15:0]                total_current_prealarm,
  output logic [3:0]                 breaker_channel_enable,
  output logic [3:0][15:0]           breaker_trip_threshold,
  output logic [3:0][15:0]           breaker_prealarm_level
);

  logic pd_tick;
  logic snap_tick;

  psumon_tick #(.PERIOD(PD_CYCLES)) u_pd_tick (
    .clock (clock),
    .srst  (srst),
    .tick  (pd_tick)
  );

  psumon_tick #(.PERIOD(SNAP_CYCLES)) u_snap_tick (
    .clock (clock),
    .srst  (srst),
    .tick  (snap_tick)
  );

  psumon_boost_limit u_boost (
    .clock  (clock),
    .srst   (srst),
    .step   (snap_tick),
    .demand (overpower_demand),
    .active (overpower_active)
  );

  // status snapshot
  logic [7:0]  nv_memory_status;
  logic [15:0] event_flags;
  logic [7:0]  next_nv_memory_status;
  logic [15:0] next_event_flags;

  always_comb begin
    next_nv_memory_status = nv_memory_status;
    next_event_flags      = event_flags;
    if (snap_tick) begin
      next_nv_memory_status                   = nv_health;
      next_event_flags                        = '0;
      next_event_flags[EV_OUTPUT_GOOD]        = output_good;
      next_event_flags[EV_OUTPUT_LOW_WARNING] = output_low_warning;
      next_event_flags[EV_OVERPOWER]          = overpower_active;
      next_event_flags[EV_CAPACITOR_OVERTEMP] = capacitor_overtemp;
      next_event_flags[EV_UNIT_OVERTEMP]      = unit_overtemp;
      next_event_flags[EV_OVERLOAD]           = overload;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      nv_memory_status <= '0;
      event_flags      <= '0;
    end else begin
      nv_memory_status <= next_nv_memory_status;
      event_flags      <= next_event_flags;
    end
  end

  // process-data image; 120 bits so every printed offset fits
  logic                next_pd_valid;
  logic [PD_WIDTH-1:0] next_pd_data;

  always_comb begin
    next_pd_valid = pd_tick;
    next_pd_data  = pd_data;
    if (pd_tick) begin
      next_pd_data = '0;
      next_pd_data[PD_TOTAL_POS +: 16] = meas_total_current;
      next_pd_data[PD_VOLT_POS +: 16]  = meas_output_voltage;
      for (int i = 0; i < CHANNELS; i++) begin
        next_pd_data[PD_CH_FIRST_POS - PD_CH_STEP * i +: 16] = meas_channel_current[i];
      end
      next_pd_data[PD_STATE_POS +: 4]    = breaker_on_state;
      next_pd_data[PD_OVERLOAD_POS +: 4] = breaker_overload_trip;
      next_pd_data[PD_SHORT_POS +: 4]    = breaker_short_trip;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pd_valid <= 1'b0;
      pd_data  <= '0;
    end else begin
      pd_valid <= next_pd_valid;
      pd_data  <= next_pd_data;
    end
  end

  // acyclic parameter access
  logic            wr;
  logic            sub_whole;
  logic            sub_chan;
  logic [1:0]      ch;
  logic            next_rsp_valid;
  logic            next_rsp_error;
  logic [15:0]     next_rdata;
  logic [15:0]     next_setpoint;
  logic            next_standby;
  logic [7:0]      next_config;
  logic [15:0]     next_total_prealarm;
  logic [3:0]      next_ch_enable;
  logic [3:0][15:0] next_trip;
  logic [3:0][15:0] next_ch_prealarm;

  assign wr        = param_req_valid && param_req_write;
  assign sub_whole = (param_subindex == SUB_WHOLE);
  assign sub_chan  = (param_subindex < SUB_CH_LIMIT);
  assign ch        = param_subindex[1:0];

  always_comb begin
    next_setpoint       = output_voltage_setpoint;
    next_standby        = standby_request;
    next_config         = config_source_select;
    next_total_prealarm = total_current_prealarm;
    next_ch_enable      = breaker_channel_enable;
    next_trip           = breaker_trip_threshold;
    next_ch_prealarm    = breaker_prealarm_level;
    next_rsp_valid      = param_req_valid;
    next_rsp_error      = 1'b0;
    next_rdata          = '0;
    if (param_req_valid) begin
      case (param_index)
        IDX_NV_STATUS: begin
          next_rdata     = {8'h00, nv_memory_status};
          next_rsp_error = param_req_write || !sub_whole;
        end
        IDX_EVENTS: begin
          // per-bit subindices are not served, only the whole word
          next_rdata     = event_flags;
          next_rsp_error = param_req_write || !sub_whole;
        end
        IDX_STANDBY: begin
          next_rdata     = {15'h0000, standby_request};
          next_rsp_error = !sub_whole;
          if (wr && sub_whole) begin
            next_standby = param_wdata[0];
          end
        end
        IDX_CONFIG: begin
          next_rdata     = {8'h00, config_source_select};
          next_rsp_error = !sub_whole || (param_req_write && param_wdata > CONFIG_MAX);
          if (wr && sub_whole && param_wdata <= CONFIG_MAX) begin
            next_config = param_wdata[7:0];
          end
        end
        IDX_TOTAL_PREALARM: begin
          next_rdata     = total_current_prealarm;
          next_rsp_error = !sub_whole;
          if (wr && sub_whole) begin
            next_total_prealarm = param_wdata;
          end
        end
        IDX_SETPOINT: begin
          next_rdata     = output_voltage_setpoint;
          next_rsp_error = !sub_whole;
          if (wr && sub_whole) begin
            next_setpoint = param_wdata;
          end
        end
        IDX_CH_ENABLE: begin
          next_rdata     = {12'h000, breaker_channel_enable};
          next_rsp_error = !sub_whole;
          if (wr && sub_whole) begin
            next_ch_enable = param_wdata[3:0];
          end
        end
        IDX_TRIP: begin
          next_rdata     = breaker_trip_threshold[ch];
          next_rsp_error = !sub_chan;
          if (wr && sub_chan) begin
            next_trip[ch] = param_wdata;
          end
        end
        IDX_CH_PREALARM: begin
          next_rdata     = breaker_prealarm_level[ch];
          next_rsp_error = !sub_chan;
          if (wr && sub_chan) begin
            next_ch_prealarm[ch] = param_wdata;
          end
        end
        default: begin
          next_rsp_error = 1'b1;
        end
      endcase
      if (next_rsp_error) begin
        next_rdata = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      output_voltage_setpoint <= RST_SETPOINT;
      standby_request         <= RST_STANDBY;
      config_source_select    <= RST_CONFIG;
      total_current_prealarm  <= RST_TOTAL_PREALARM;
      breaker_channel_enable  <= RST_CH_ENABLE;
      breaker_trip_threshold  <= {CHANNELS{RST_TRIP}};
      breaker_prealarm_level  <= {CHANNELS{RST_CH_PREALARM}};
      param_rsp_valid         <= 1'b0;
      param_rsp_error         <= 1'b0;
      param_rdata             <= '0;
    end else begin
      output_voltage_setpoint <= next_setpoint;
      standby_request         <= next_standby;
      config_source_select    <= next_config;
      total_current_prealarm  <= next_total_prealarm;
      breaker_channel_enable  <= next_ch_enable;
      breaker_trip_threshold  <= next_trip;
      breaker_prealarm_level  <= next_ch_prealarm;
      param_rsp_valid         <= next_rsp_valid;
      param_rsp_error         <= next_rsp_error;
      param_rdata             <= next_rdata;
    end
  end

  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  logic [19:0] pd_gap;
  logic        pd_seen;
  always_ff @(posedge clock) begin
    if (srst) begin
      pd_gap  <= '0;
      pd_seen <= 1'b0;
    end else begin
      pd_gap  <= pd_valid ? 20'h0_0001 : pd_gap + 20'h0_0001;
      pd_seen <= pd_seen | pd_valid;
    end
  end

  pd_period_a: assert property (
    pd_valid && pd_seen |-> pd_gap == 20'(PD_CYCLES)) else $error("process data period wrong");

  snap_hold_a: assert property (
    !snap_tick |=> $stable(event_flags) && $stable(nv_memory_status)) else $error("status changed between refreshes");

  pd_fields_a: assert property (
    pd_valid |-> pd_data[PD_TOTAL_POS +: 16] == $past(meas_total_current)
      && pd_data[PD_VOLT_POS +: 16] == $past(meas_output_voltage)
      && pd_data[PD_CH_FIRST_POS - 3 * PD_CH_STEP +: 16] == $past(meas_channel_current[3]))
    else $error("process data measurement misplaced");

  pd_breaker_a: assert property (
    pd_valid |-> pd_data[PD_STATE_POS +: 4] == $past(breaker_on_state)
      && pd_data[PD_OVERLOAD_POS +: 4] == $past(breaker_overload_trip)
      && pd_data[PD_SHORT_POS +: 4] == $past(breaker_short_trip))
    else $error("process data breaker bits misplaced");

  event_map_a: assert property (
    snap_tick |=> event_flags[5:0] == $past({overload, unit_overtemp, capacitor_overtemp,
      overpower_active, output_low_warning, output_good})) else $error("event word bit map wrong");

  sequence setpoint_write_s;
    param_req_valid && param_req_write && param_index == IDX_SETPOINT && param_subindex == SUB_WHOLE;
  endsequence

  setpoint_apply_a: assert property (
    setpoint_write_s |=> param_rsp_valid && !param_rsp_error
      && output_voltage_setpoint == $past(param_wdata)) else $error("setpoint write not applied");

  reset_defaults_a: assert property (
    $past(srst) |-> total_current_prealarm == RST_TOTAL_PREALARM
      && breaker_trip_threshold[0] == RST_TRIP && breaker_prealarm_level[3] == RST_CH_PREALARM)
    else $error("reset defaults wrong");

  sequence nv_read_s;
    param_req_valid && !param_req_write && param_index == IDX_NV_STATUS && param_subindex == SUB_WHOLE;
  endsequence

  nv_read_a: assert property (
    nv_read_s |=> param_rsp_valid && param_rdata == {8'h00, $past(nv_memory_status)})
    else $error("memory status read wrong");

  config_reject_a: assert property (
    param_req_valid && param_req_write && param_index == IDX_CONFIG && param_wdata > CONFIG_MAX
      |=> param_rsp_error && $stable(config_source_select)) else $error("bad configuration write kept");

  ro_reject_a: assert property (
    param_req_valid && param_req_write && param_index == IDX_EVENTS
      |=> param_rsp_valid && param_rsp_error && param_rdata == 16'h0000) else $error("read-only write accepted");

endmodule

// *** dv/psumon_master_model.sv ***
/*
  Link master model: issues one parameter request at a time and collects the answer.
  Assumes the device registers the answer on the taking edge; it is read at the next falling edge.
*/
`timescale 1ns/1ps
module psumon_master_model (
  input  wire logic        clock,
  output logic             param_req_valid,
  output logic             param_req_write,
  output logic [7:0]       param_index,
  output logic [7:0]       param_subindex,
  output logic [15:0]      param_wdata,
  input  wire logic        param_rsp_valid,
  input  wire logic        param_rsp_error,
  input  wire logic [15:0] param_rdata
);
  initial begin
    param_req_valid = 1'b0;
    {param_req_write, param_index, param_subindex, param_wdata} = '0;
  end
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] sub,
                      input logic [15:0] wd, output logic [17:0] rsp);
    @(negedge clock);
    param_req_valid = 1'b1;
    param_req_write = wr;
    param_index = idx;
    param_subindex = sub;
    param_wdata = wd;
    @(posedge clock);
    @(negedge clock);
    rsp = {param_rsp_valid, param_rsp_error, param_rdata};
    param_req_valid = 1'b0;
    // released fields flip so a stale value cannot pass unnoticed
    {param_req_write, param_index, param_subindex, param_wdata} =
      ~{param_req_write, param_index, param_subindex, param_wdata};
  endtask
endmodule

// *** dv/psumon_param_map_test.sv ***
/*
  Self-checking bench for the parameter block: defaults, writes and refusals,
  status snapshots, process-data image and overpower limit. Inputs move on falling edges.
*/
`timescale 1ns/1ps
module psumon_param_map_test;
  import psumon_pkg::*;
  localparam int unsigned PD = 20;
  localparam int unsigned SN = 50;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic v, w, rv, re, pv, good, warn, cap, hot, ovl, dem, act, stby;
  logic [7:0] idx, sub, nvh, cfg;
  logic [15:0] wd, rdt, tot, volt, setp, tpa;
  logic [3:0] on_s, ovt, sht, ena;
  logic [3:0][15:0] chc, trip, cpa;
  logic [PD_WIDTH-1:0] pdd;
  logic [17:0] r;
  logic [32:0] wt [12];
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;

  always #50 clock = ~clock;

  psumon_master_model m (.clock(clock), .param_req_valid(v), .param_req_write(w), .param_index(idx),
    .param_subindex(sub), .param_wdata(wd), .param_rsp_valid(rv), .param_rsp_error(re), .param_rdata(rdt));

  psumon_param_map #(.PD_CYCLES(PD), .SNAP_CYCLES(SN)) DUT (.clock(clock), .srst(srst),
    .param_req_valid(v), .param_req_write(w), .param_index(idx), .param_subindex(sub), .param_wdata(wd),
    .param_rsp_valid(rv), .param_rsp_error(re), .param_rdata(rdt), .pd_valid(pv), .pd_data(pdd),
    .meas_total_current(tot), .meas_output_voltage(volt), .meas_channel_current(chc),
    .breaker_on_state(on_s), .breaker_overload_trip(ovt), .breaker_short_trip(sht), .nv_health(nvh),
    .output_good(good), .output_low_warning(warn), .capacitor_overtemp(cap), .unit_overtemp(hot),
    .overload(ovl), .overpower_demand(dem), .overpower_active(act), .output_voltage_setpoint(setp),
    .standby_request(stby), .config_source_select(cfg), .total_current_prealarm(tpa),
    .breaker_channel_enable(ena), .breaker_trip_threshold(trip), .breaker_prealarm_level(cpa));

  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    // whole run needs about 15k cycles
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [PD_WIDTH-1:0] got, input logic [PD_WIDTH-1:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] s, input logic e, input logic [15:0] x);
    m.xfer(1'b0, i, s, 16'h0000, r);
    chk(r, {1'b1, e, x}, "read");
  endtask

  initial begin
    {tot, volt, chc, on_s, ovt, sht} = '0;
    {good, warn, cap, hot, ovl, dem} = '0;
    nvh = 8'h02;
    repeat (20) @(negedge clock);
    srst = 1'b0;
    rd(IDX_NV_STATUS, 8'h00, 1'b0, 16'h0000);
    rd(IDX_SETPOINT, 8'h00, 1'b0, 16'h0992);
    rd(IDX_STANDBY, 8'h00, 1'b0, 16'h0000);
    rd(IDX_CONFIG, 8'h00, 1'b0, 16'h0002);
    rd(IDX_TOTAL_PREALARM, 8'h00, 1'b0, 16'h07d0);
    rd(IDX_CH_ENABLE, 8'h00, 1'b0, 16'h000f);
    for (int j = 0; j < 4; j++) begin
      rd(IDX_TRIP, 8'(j), 1'b0, 16'hffff);
      rd(IDX_CH_PREALARM, 8'(j), 1'b0, 16'h1f62);
    end
    wt = '{{8'h69, 8'h00, 16'h0a28, 1'b0}, {8'h65, 8'h00, 16'h0001, 1'b0}, {8'h67, 8'h00, 16'h0003, 1'b0},
           {8'h68, 8'h00, 16'h0100, 1'b0}, {8'h6a, 8'h00, 16'h0005, 1'b0}, {8'h6c, 8'h03, 16'h1234, 1'b0},
           {8'h6d, 8'h03, 16'h0800, 1'b0}, {8'h67, 8'h00, 16'h0004, 1'b1}, {8'h6c, 8'h04, 16'h0001, 1'b1},
           {8'h40, 8'h00, 16'h0001, 1'b1}, {8'h41, 8'h00, 16'h0001, 1'b1}, {8'h50, 8'h00, 16'h0001, 1'b1}};
    foreach (wt[k]) begin
      m.xfer(1'b1, wt[k][32:25], wt[k][24:17], wt[k][16:1], r);
      chk(r[17:16], {1'b1, wt[k][0]}, "write answer");
      if (!wt[k][0])
        rd(wt[k][32:25], wt[k][24:17], 1'b0, wt[k][16:1]);
    end
    rd(IDX_CONFIG, 8'h00, 1'b0, 16'h0003);
    rd(IDX_EVENTS, 8'h01, 1'b1, 16'h0000);
    chk({setp, stby, cfg, tpa, ena, trip[3], cpa[3]}, {16'h0a28, 1'b1, 8'h03, 16'h0100, 4'h5, 16'h1234,
        16'h0800}, "config ports");
    for (int k = 0; k < 3; k++) begin
      nvh = 8'(k);
      {ovl, hot, cap, warn, good} = 5'(5'h15 + 5'(k) * 5'h07);
      repeat (SN + 3) @(negedge clock);
      rd(IDX_NV_STATUS, 8'h00, 1'b0, 16'(k));
      rd(IDX_EVENTS, 8'h00, 1'b0, {10'h000, ovl, hot, cap, 1'b0, warn, good});
    end
    tot = 16'h1111;
    volt = 16'h0992;
    chc = {16'h4444, 16'h3333, 16'h2222, 16'h1234};
    {on_s, ovt, sht} = 12'ha5c;
    n = 0;
    while (pv !== 1'b1 && n < 3 * PD) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    n = 1;
    while (pv !== 1'b1 && n < 3 * PD) begin
      @(negedge clock);
      n++;
    end
    chk(n, PD, "image period");
    chk(pdd, {tot, volt, chc[0], chc[1], chc[2], chc[3], 4'h0, on_s, 4'h0, ovt, 4'h0, sht},
        "image");
    dem = 1'b1;
    @(negedge clock);
    chk(act, 1'b1, "overpower grant");
    n = 0;
    while (act === 1'b1 && n < BOOST_MAX_TICKS * SN + 10) begin
      @(negedge clock);
      n++;
    end
    chk({act, n > (BOOST_MAX_TICKS - 1) * SN && n <= BOOST_MAX_TICKS * SN}, 2'b01, "overpower limited");
    n = 0;
    while (act !== 1'b1 && n < BOOST_REST_TICKS * SN + 10) begin
      @(negedge clock);
      n++;
    end
    chk({act, n}, {1'b1, 32'(BOOST_REST_TICKS * SN + 1)}, "overpower again");
    // releasing demand early must still cost a rest: no grant one refresh period later
    dem = 1'b0;
    @(negedge clock);
    dem = 1'b1;
    repeat (SN) @(negedge clock);
    chk(act, 1'b0, "rest after early drop");
    finish_test();
  end
endmodule
